// file: rtl/ptm_pkg.sv
// Package with register map, field layout, reset values and modes of the period timer.
package ptm_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [4:0] OFF_COUNT   = 5'h00;
  localparam logic [4:0] OFF_PERIOD  = 5'h04;
  localparam logic [4:0] OFF_CONTROL = 5'h08;
  localparam logic [4:0] OFF_HALT    = 5'h0c;
  localparam logic [4:0] OFF_RSTSEL  = 5'h10;
  localparam logic [4:0] OFF_STATUS  = 5'h14;
  // Control register fields.
  localparam int CTL_RUN_BIT   = 7;
  localparam int CTL_PRE_LSB   = 4;
  localparam int CTL_POST_LSB  = 0;
  // Halt/mode register fields.
  localparam int HLT_MODE_LSB  = 0;
  // Reset values.
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  // Mode groups held in the upper two mode bits.
  localparam logic [1:0] GRP_FREE     = 2'h0;
  localparam logic [1:0] GRP_ONESHOT  = 2'h1;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {PTM_IDLE, PTM_RESP} ptm_bus_e;
endpackage

// file: rtl/ptm_prescale.sv
// Prescaler that emits one enable pulse every 2^sel input clocks.
module ptm_prescale #(
  parameter int SEL_W = 3,
  parameter int CNT_W = 7
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Control.
  input  wire logic             clear,
  input  wire logic [SEL_W-1:0] sel,
  // Output.
  output logic                  tick,
  output logic                  full
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] limit;
  always_comb begin
    limit    = CNT_W'((1 << sel) - 1);
    full     = (cnt == limit);
    tick     = full && !clear;
    next_cnt = (clear || full) ? '0 : cnt + 1'b1;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// file: rtl/ptm_sync.sv
// Two-flop synchroniser for one level.
module ptm_sync (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Level in and out.
  input  wire logic din,
  output logic      dout
);
  logic meta;
  logic next_meta;
  logic next_dout;
  always_comb begin
    next_meta = din;
    next_dout = meta;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule

// file: rtl/ptm_timer.sv
// Period timer with prescaler, postscaler, modes and AXI4-Lite registers.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
module ptm_timer
  import ptm_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // AXI4-Lite write address and data.
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External reset source and debug freeze.
  input  wire logic        external_reset_input,
  input  wire logic        debug_freeze,
  // Outputs to peripherals and the PWM unit.
  output logic             postscaled_tick,
  output logic [7:0]       pwm_timer_count,
  output logic             pwm_period_match,
  output logic             pwm_timer_tick
);
  // Registers.
  logic [7:0] timer_count, period_value, period_active;
  logic [7:0] timer_control_reg, halt_mode_reg;
  logic [7:0] reset_source_select;
  logic [3:0] post_cnt;
  logic       match_d, ers_d;
  logic [7:0] next_timer_count, next_period_value, next_period_active;
  logic [7:0] next_timer_control_reg, next_halt_mode_reg, next_reset_source_select;
  logic [3:0] next_post_cnt;
  logic       next_match_d, next_ers_d, next_tick;
  // Bus state.
  ptm_bus_e   wst, next_wst, rst_q, next_rst;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  // Internal.
  logic       ers_sync, ers_rise, ers_fall, ers_level, freeze;
  logic       pre_tick, pre_full, pre_clear;
  logic       wr_go, wr_cnt, wr_ctl, wr_hlt, wr_per;
  logic       run, mode_run, hw_reset, match, oneshot_stop;
  logic [1:0] grp;
  logic [2:0] sub;
  logic       post_clr_ers;
  logic       mono_done, next_mono_done, start_edge;

  ptm_sync u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .din     (external_reset_input),
    .dout    (ers_sync)
  );

  ptm_prescale #(.SEL_W(3), .CNT_W(7)) u_pre (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clear   (pre_clear),
    .sel     (timer_control_reg[CTL_PRE_LSB +: 3]),
    .tick    (pre_tick),
    .full    (pre_full)
  );

  // Bus write decode: both channels taken together in one cycle.
  always_comb begin
    wr_go  = s_axi_awvalid && s_axi_wvalid && (wst == PTM_IDLE);
    s_axi_awready = wr_go;
    s_axi_wready  = wr_go;
    s_axi_arready = (rst_q == PTM_IDLE);
    wr_cnt = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_COUNT);
    wr_per = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_PERIOD);
    wr_ctl = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_CONTROL);
    wr_hlt = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_HALT);
  end

  // Mode decode and trigger detection.
  always_comb begin
    run     = timer_control_reg[CTL_RUN_BIT];
    grp     = halt_mode_reg[HLT_MODE_LSB+3 +: 2];
    sub     = halt_mode_reg[HLT_MODE_LSB +: 3];
    freeze  = debug_freeze;
    ers_rise  = !freeze && ers_sync && !ers_d;
    ers_fall  = !freeze && !ers_sync && ers_d;
    ers_level = ers_sync;
    mode_run = 1'b0;
    hw_reset = 1'b0;
    start_edge = 1'b0;
    if (grp == GRP_FREE) begin
      unique case (sub)
        3'h0: mode_run = run;
        3'h1: mode_run = run && (freeze ? 1'b0 : ers_level);
        3'h2: mode_run = run && (freeze ? 1'b0 : !ers_level);
        3'h3: begin mode_run = run; hw_reset = ers_rise || ers_fall; end
        3'h4: begin mode_run = run; hw_reset = ers_rise; end
        3'h5: begin mode_run = run; hw_reset = ers_fall; end
        3'h6: begin mode_run = run && ers_level; hw_reset = !freeze && !ers_level; end
        3'h7: begin mode_run = run && !ers_level; hw_reset = !freeze && ers_level; end
      endcase
    end else begin
      // Started modes run once the run bit is set, except sub-mode 0 outside the one-shot group; edge resets restart.
      mode_run = run;
      unique case (sub)
        3'h4: hw_reset = ers_rise;
        3'h5: hw_reset = ers_fall;
        3'h6: hw_reset = !freeze && !ers_level;
        3'h7: hw_reset = !freeze && ers_level;
        default: hw_reset = 1'b0;
      endcase
      if (grp != GRP_ONESHOT && sub == 3'h0) begin
        mode_run = 1'b0;
      end
      unique case (sub)
        3'h0: start_edge = 1'b0;
        3'h1, 3'h4, 3'h6: start_edge = ers_rise;
        3'h2, 3'h5, 3'h7: start_edge = ers_fall;
        3'h3: start_edge = ers_rise || ers_fall;
      endcase
      if (mono_done) begin
        mode_run = 1'b0;
        hw_reset = start_edge;
      end
    end
    match = pre_tick && mode_run && (timer_count == period_active);
    oneshot_stop = match && (grp != GRP_FREE);
    pre_clear = wr_cnt || wr_ctl || hw_reset;
    post_clr_ers = pre_clear;
  end

  // Timer state next values.
  always_comb begin
    next_timer_count         = timer_count;
    next_period_value        = period_value;
    next_period_active       = period_active;
    next_timer_control_reg   = timer_control_reg;
    next_halt_mode_reg       = halt_mode_reg;
    next_reset_source_select = reset_source_select;
    next_post_cnt            = post_cnt;
    next_tick                = 1'b0;
    next_match_d             = match;
    next_ers_d               = ers_sync;
    next_mono_done           = mono_done;
    if (wr_per) next_period_value = s_axi_wdata[7:0];
    if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFF_RSTSEL)
      next_reset_source_select = s_axi_wdata[7:0];
    if (wr_hlt) next_halt_mode_reg = {3'h0, s_axi_wdata[4:0]};
    if (match) begin
      next_timer_count = COUNT_RESET;
      if (post_cnt == timer_control_reg[CTL_POST_LSB +: 4]) begin
        next_tick     = 1'b1;
        next_post_cnt = '0;
      end else begin
        next_post_cnt = post_cnt + 1'b1;
      end
      if (grp == GRP_ONESHOT) next_timer_control_reg[CTL_RUN_BIT] = 1'b0;
    end else if (pre_tick && mode_run && !oneshot_stop) begin
      next_timer_count = timer_count + 1'b1;
    end
    if (hw_reset) next_timer_count = COUNT_RESET;
    if (post_clr_ers) next_post_cnt = '0;
    if (wr_ctl && s_axi_wdata[CTL_RUN_BIT] && !run) next_post_cnt = '0;
    if (wr_ctl) next_timer_control_reg = s_axi_wdata[7:0];
    if (wr_cnt) next_timer_count = s_axi_wdata[7:0];
    if (wr_cnt || wr_ctl || wr_hlt || (match && pre_full) || hw_reset)
      next_period_active = period_value;
    if (!grp[1] || wr_ctl || wr_cnt || (mono_done && start_edge)) next_mono_done = 1'b0;
    if (match && grp[1]) next_mono_done = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_count         <= COUNT_RESET;
      period_value        <= PERIOD_RESET;
      period_active       <= PERIOD_RESET;
      timer_control_reg   <= 8'h00;
      halt_mode_reg       <= 8'h00;
      reset_source_select <= 8'h00;
      post_cnt            <= 4'h0;
      postscaled_tick     <= 1'b0;
      match_d             <= 1'b0;
      ers_d               <= 1'b0;
      mono_done           <= 1'b0;
    end else begin
      timer_count         <= next_timer_count;
      period_value        <= next_period_value;
      period_active       <= next_period_active;
      timer_control_reg   <= next_timer_control_reg;
      halt_mode_reg       <= next_halt_mode_reg;
      reset_source_select <= next_reset_source_select;
      post_cnt            <= next_post_cnt;
      postscaled_tick     <= next_tick;
      match_d             <= next_match_d;
      ers_d               <= next_ers_d;
      mono_done           <= next_mono_done;
    end
  end

  always_comb begin
    pwm_timer_count  = timer_count;
    pwm_period_match = match_d;
    pwm_timer_tick   = postscaled_tick;
  end

  // Bus response next values.
  always_comb begin
    next_wst   = wst;
    next_rst   = rst_q;
    next_bresp = s_axi_bresp;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (wr_go) begin
      next_wst   = PTM_RESP;
      next_bresp = (s_axi_awaddr <= OFF_RSTSEL && s_axi_awaddr[1:0] == 2'h0)
                   ? RESP_OKAY : RESP_SLVERR;
    end else if (wst == PTM_RESP && s_axi_bready) begin
      next_wst = PTM_IDLE;
    end
    if (s_axi_arvalid && rst_q == PTM_IDLE) begin
      next_rst   = PTM_RESP;
      next_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_COUNT:   next_rdata = {24'h0, timer_count};
        OFF_PERIOD:  next_rdata = {24'h0, period_value};
        OFF_CONTROL: next_rdata = {24'h0, timer_control_reg};
        OFF_HALT:    next_rdata = {24'h0, halt_mode_reg};
        OFF_RSTSEL:  next_rdata = {24'h0, reset_source_select};
        OFF_STATUS:  next_rdata = {19'h0, ers_sync, post_cnt, period_active};
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rst_q == PTM_RESP && s_axi_rready) begin
      next_rst = PTM_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wst         <= PTM_IDLE;
      rst_q       <= PTM_IDLE;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      wst         <= next_wst;
      rst_q       <= next_rst;
      s_axi_bresp <= next_bresp;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  always_comb begin
    s_axi_bvalid = (wst == PTM_RESP);
    s_axi_rvalid = (rst_q == PTM_RESP);
  end
endmodule

// file: sim/ptm_peer.sv
// Model of the peripherals around the timer: trigger source and tick consumer.
module ptm_peer (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Requested trigger level and the timer's tick.
  input  wire logic want,
  input  wire logic postscaled_tick,
  // Trigger line and ticks seen.
  output logic      trig,
  output int        seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig <= 1'b0;
      hold <= 0;
      seen <= 0;
    end else begin
      hold <= hold + 1;
      if (want != trig && hold >= 8) begin
        trig <= want;
        hold <= 0;
      end
      if (postscaled_tick) begin
        seen <= seen + 1;
      end
    end
  end
endmodule

// file: sim/ptm_timer_props.sv
// Checker of bus handshakes, counting and tick output of the period timer.
module ptm_timer_props
  import ptm_pkg::*;
(
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Register bus.
  input wire logic [4:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Timer outputs.
  input wire logic        postscaled_tick,
  input wire logic [7:0]  pwm_timer_count,
  input wire logic        pwm_period_match,
  input wire logic        pwm_timer_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
  a_bresp_next: assert property (wr_go |=> s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rresp_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_count_write: assert property (wr_go && s_axi_awaddr == OFF_COUNT && s_axi_wstrb[0]
    |=> {24'h0, pwm_timer_count} == ($past(s_axi_wdata) & 32'hff)) else $error("count write lost");
  a_count_step: assert property ($changed(pwm_timer_count) && !$past(wr_go)
    |-> pwm_timer_count == 8'($past(pwm_timer_count) + 8'h01) || pwm_timer_count == 8'h00)
    else $error("count jumped");
  a_match_zero: assert property (pwm_period_match && !$past(wr_go)
    |-> pwm_timer_count == 8'h00) else $error("count not cleared on match");
  a_tick_match: assert property (postscaled_tick |-> pwm_period_match)
    else $error("tick without match");
  a_tick_single: assert property (postscaled_tick |=> !postscaled_tick)
    else $error("tick too long");
  a_tick_copy: assert property (pwm_timer_tick == postscaled_tick)
    else $error("tick copy differs");
endmodule

bind ptm_timer ptm_timer_props props_u (.*);

// file: sim/ptm_timer_tb.sv
// Self-checking bench of the period timer.
module ptm_timer_tb
  import ptm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset_n = 1'b0, want = 1'b0, debug_freeze = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic postscaled_tick, trig;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  logic [7:0] got, per;
  logic [3:0] post;
  int seen, n0, bad_count = 0, comparisons = 0;
  ptm_timer dut_u (.*, .external_reset_input(trig), .pwm_timer_count(),
    .pwm_period_match(), .pwm_timer_tick());
  ptm_peer peer_u (.*);
  always #5 ref_clk = ~ref_clk;
  function automatic logic [33:0] okv(input logic [7:0] v);
    return {RESP_OKAY, 24'h0, v};
  endfunction
  task automatic check(input string what, input logic [33:0] ex, input logic [33:0] sn);
    comparisons++;
    if (sn !== ex) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, ex, sn);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", {32'h0, er}, {32'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [4:0] a, input logic [33:0] ex, input logic chk);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    exp_q.push_back({chk, ex});
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    got = s_axi_rdata[7:0];
  endtask
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[34]) begin
        check("read data", e[33:0], {s_axi_rresp, s_axi_rdata});
      end
    end
  end
  initial begin
    idle(20000);
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h55d5));
    idle(6);
    reset_n <= 1'b1;
    rd(OFF_PERIOD, okv(PERIOD_RESET), 1'b1);
    rd(OFF_COUNT, okv(COUNT_RESET), 1'b1);
    rd(OFF_STATUS, okv(8'hff), 1'b1);
    rd(5'h18, {RESP_SLVERR, 32'h0}, 1'b1);
    wr(5'h1c, 8'h00, RESP_SLVERR);
    wr(OFF_HALT, 8'h08, RESP_OKAY);
    for (int p = 0; p < 8; p++) begin
      per = 8'($urandom_range(7, 1));
      n0 = seen;
      wr(OFF_PERIOD, per, RESP_OKAY);
      wr(OFF_CONTROL, 8'h80 | 8'(p << 4), RESP_OKAY);
      idle(((per + 2) << p) + 20);
      rd(OFF_CONTROL, okv(8'(p << 4)), 1'b1);
      rd(OFF_COUNT, okv(8'h00), 1'b1);
      check("one-shot ticks", 34'(n0 + 1), 34'(seen));
    end
    wr(OFF_COUNT, 8'h5a, RESP_OKAY);
    wr(OFF_CONTROL, 8'h00, RESP_OKAY);
    rd(OFF_COUNT, okv(8'h5a), 1'b1);
    wr(OFF_PERIOD, 8'h33, RESP_OKAY);
    rd(OFF_STATUS, okv(per), 1'b1);
    wr(OFF_HALT, 8'h00, RESP_OKAY);
    rd(OFF_STATUS, okv(8'h33), 1'b1);
    for (int k = 0; k < 3; k++) begin
      per = 8'($urandom_range(3, 1));
      post = (k == 0) ? 4'hf : 4'($urandom_range(15, 0));
      wr(OFF_PERIOD, per, RESP_OKAY);
      wr(OFF_CONTROL, {4'h8, post}, RESP_OKAY);
      // Zero the count so that the window sees a steady tick train.
      wr(OFF_COUNT, 8'h00, RESP_OKAY);
      idle(4);
      n0 = seen;
      idle(4 * (per + 1) * (post + 1));
      check("tick rate", 34'(n0 + 4), 34'(seen));
    end
    wr(OFF_PERIOD, 8'hff, RESP_OKAY);
    wr(OFF_HALT, 8'h01, RESP_OKAY);
    wr(OFF_COUNT, 8'h10, RESP_OKAY);
    idle(10);
    rd(OFF_COUNT, okv(8'h10), 1'b1);
    debug_freeze <= 1'b1;
    want <= 1'b1;
    idle(20);
    rd(OFF_COUNT, okv(8'h10), 1'b1);
    debug_freeze <= 1'b0;
    idle(20);
    rd(OFF_COUNT, 34'h0, 1'b0);
    check("gate open", 34'h1, 34'(got > 8'h10));
    want <= 1'b0;
    idle(20);
    rd(OFF_COUNT, 34'h0, 1'b0);
    rd(OFF_COUNT, okv(got), 1'b1);
    wr(OFF_HALT, 8'h07, RESP_OKAY);
    want <= 1'b1;
    idle(20);
    rd(OFF_COUNT, okv(8'h00), 1'b1);
    want <= 1'b0;
    wr(OFF_CONTROL, 8'h00, RESP_OKAY);
    wr(OFF_PERIOD, 8'h03, RESP_OKAY);
    wr(OFF_HALT, 8'h11, RESP_OKAY);
    wr(OFF_COUNT, 8'h00, RESP_OKAY);
    n0 = seen;
    wr(OFF_CONTROL, 8'h80, RESP_OKAY);
    idle(30);
    rd(OFF_CONTROL, okv(8'h80), 1'b1);
    want <= 1'b1;
    idle(30);
    check("restart ticks", 34'(n0 + 2), 34'(seen));
    wrap_up();
  end
endmodule
